//--- radio_ctl_pkg.sv
package radio_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLOCK_MHZ        = 250;                          // Crystal-side clock rate
  localparam int OSC_START_US     = 150;                          // Oscillator settle time
  localparam int OSC_START_CYCLES = OSC_START_US * CLOCK_MHZ;     // Settle time in cycles
  localparam int RESTART_NS       = 400;                          // Busy time after reset strobe
  localparam int RESTART_CYCLES   = (RESTART_NS * CLOCK_MHZ + 999) / 1000;
  localparam int GDO_CLOCK_DIV    = 192;                          // Default output divider
  localparam int GDO_HALF         = GDO_CLOCK_DIV / 2;            // Toggle interval

  ////////////////////////////////////////////////////////////////////////////
  // Output selections for general_output_zero
  localparam logic [5:0] GDO_SEL_CARRIER = 6'h0E;                 // Carrier sense
  localparam logic [5:0] GDO_SEL_CLK_DIV = 6'h3F;                 // Clock divided by 192

  ////////////////////////////////////////////////////////////////////////////
  // Radio state codes
  localparam logic [4:0] CODE_SLEEP       = 5'h00;
  localparam logic [4:0] CODE_IDLE        = 5'h01;
  localparam logic [4:0] CODE_OSC_OFF     = 5'h02;
  localparam logic [4:0] CODE_RX          = 5'h0D;
  localparam logic [4:0] CODE_RX_OVERFLOW = 5'h11;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier-sense threshold model, half-dB units
  localparam logic signed [9:0] CS_BASE_HALF  = 10'sh33D;         // Base level, -195
  localparam logic signed [9:0] CS_LNA_STEP   = 10'sh005;         // Per front-end step
  localparam logic signed [9:0] CS_DVGA_STEP  = 10'sh00C;         // Per digital step
  localparam logic signed [9:0] CS_TGT_STEP   = 10'sh004;         // Per target step
  localparam logic signed [9:0] CS_HYST_HALF  = 10'sh002;         // Hysteresis band
  localparam logic signed [4:0] CS_OFFSET_MAX = 5'sh07;           // Offset limit, dB
  localparam logic signed [9:0] CS_REL_6DB    = 10'sh00C;
  localparam logic signed [9:0] CS_REL_10DB   = 10'sh014;
  localparam logic signed [9:0] CS_REL_14DB   = 10'sh01C;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_SLEEP, ST_IDLE, ST_OSC_OFF, ST_RX, ST_RX_OVERFLOW
  } radio_state_t;

  typedef struct packed {
    logic       osc_force_on;             // Keep crystal running
    logic [5:0] general_output_zero_sel;                 // general_output_zero source
    logic [2:0] front_end_gain_ceiling;
    logic [1:0] digital_gain_ceiling;
    logic [2:0] channel_level_target;
    logic [3:0] cs_absolute_offset;       // Signed dB offset
    logic [1:0] cs_relative_step;         // 0 off, 1..3 = 6/10/14 dB
  } cfg_t;

  typedef struct packed {
    logic reset_strobe;
    logic osc_off_strobe;
    logic power_down_strobe;
    logic idle_strobe;
    logic rx_strobe;
  } strobes_t;

  localparam cfg_t CFG_RESET = '{osc_force_on: 1'b0, general_output_zero_sel: GDO_SEL_CLK_DIV,
                                 front_end_gain_ceiling: 3'h0, digital_gain_ceiling: 2'h0,
                                 channel_level_target: 3'h3, cs_absolute_offset: 4'h0,
                                 cs_relative_step: 2'h0};

endpackage

//--- carrier_sense_unit.sv
`timescale 1ns/100ps
`default_nettype none
module carrier_sense_unit import radio_ctl_pkg::*; (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clear,
  input  wire cfg_t        cfg,
  input  wire logic [7:0]  rssi,
  input  wire logic        rssi_valid,
  output logic             carrier_sense
);

  ////////////////////////////////////////////////////////////////////////////
  // Threshold from gain ceilings, target and clamped offset
  function automatic logic signed [9:0] cs_threshold(input cfg_t c);
    logic signed [4:0] ofs;
    ofs = $signed({c.cs_absolute_offset[3], c.cs_absolute_offset});
    if (ofs < -CS_OFFSET_MAX) ofs = -CS_OFFSET_MAX;                  // [R2]
    cs_threshold = CS_BASE_HALF                                       // [R1]
                 + CS_LNA_STEP * $signed({7'h00, c.front_end_gain_ceiling})
                 + CS_DVGA_STEP * $signed({8'h00, c.digital_gain_ceiling})
                 + CS_TGT_STEP * $signed({7'h00, c.channel_level_target})
                 + {{4{ofs[4]}}, ofs, 1'b0};                          // [R2]
  endfunction

  logic signed [9:0] thr;            // Current absolute threshold
  logic signed [9:0] level;          // Sign-extended sample
  logic signed [9:0] prev;           // Sign-extended previous sample
  logic signed [9:0] step;           // Relative step size
  logic [7:0]        prev_r, prev_nxt;
  logic              seen_r, seen_nxt;
  logic              abs_r, abs_nxt;
  logic              rel_r, rel_nxt;
  logic              cs_r, cs_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Absolute and relative detection
  always_comb begin
    thr      = cs_threshold(cfg);
    level    = $signed({{2{rssi[7]}}, rssi});
    prev     = $signed({{2{prev_r[7]}}, prev_r});
    prev_nxt = prev_r;
    seen_nxt = seen_r;
    abs_nxt  = abs_r;
    rel_nxt  = rel_r;
    case (cfg.cs_relative_step)
      2'h1:    step = CS_REL_6DB;                                     // [R5]
      2'h2:    step = CS_REL_10DB;
      2'h3:    step = CS_REL_14DB;
      default: step = 10'sh000;
    endcase
    if (rssi_valid) begin
      // Hysteresis around the absolute level
      if (!abs_r && level > thr + CS_HYST_HALF) abs_nxt = 1'b1;       // [R21]
      else if (abs_r && level < thr - CS_HYST_HALF) abs_nxt = 1'b0;   // [R21]
      // Sample-to-sample change detection
      if (cfg.cs_relative_step == 2'h0) begin
        rel_nxt = 1'b0;                                               // [R5]
      end else if (seen_r && level - prev >= step) begin
        rel_nxt = 1'b1;                                               // [R5]
      end else if (seen_r && prev - level >= step) begin
        rel_nxt = 1'b0;
      end
      prev_nxt = rssi;
      seen_nxt = 1'b1;
    end
    if (clear) begin
      seen_nxt = 1'b0;
      abs_nxt  = 1'b0;
      rel_nxt  = 1'b0;
    end
    cs_nxt = abs_nxt | rel_nxt;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prev_r <= 8'h00;
      seen_r <= 1'b0;
      abs_r  <= 1'b0;
      rel_r  <= 1'b0;
      cs_r   <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      seen_r <= seen_nxt;
      abs_r  <= abs_nxt;
      rel_r  <= rel_nxt;
      cs_r   <= cs_nxt;
    end
  end

  assign carrier_sense = cs_r;

  property p_cs_off_rel;
    @(posedge clock) disable iff (reset)
      (cfg.cs_relative_step == 2'h0 && rssi_valid && !clear) |=> !rel_r;
  endproperty
  a_cs_off_rel: assert property (p_cs_off_rel) // [R5]
    else $error("Relative detect active while disabled");

endmodule
`default_nettype wire

//--- radio_reset_xosc_control.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: Threshold combines gains, target and offset
// R2: Offset moves threshold +-7 dB, 1 dB
// R3: Offset resets to zero
// R4: Controller lowers front-end gain before digital; no gain control here, the ceilings only feed the carrier-sense threshold
// R5: Relative detect off or 6/10/14 dB
// R6: States follow strobes and internal events
// R7: Output zero carries clock/192 after reset
// R8: Ready low on data out when selected
// R9: After reset idle, oscillator running
// R10: Ready high until oscillator stable
// R11: Reset strobe restores defaults and idle
// R12: Controller pulses select for manual reset
// R13: Controller waits ready, strobes, waits again
// R14: Later resets use strobe only
// R15: Force bit keeps oscillator running
// R16: Off and sleep strobes honored from idle
// R17: Crystal stops on select rise, restarts on fall
// R18: State code readable for test
// R19: Forced oscillator runs in sleep too
// R20: Select low in sleep wakes to idle
// R21: Absolute carrier sense with hysteresis
module radio_reset_xosc_control import radio_ctl_pkg::*; #(
  parameter int OSC_START_CYC = OSC_START_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       select_n,
  input  wire strobes_t   strobes,
  input  wire logic       cfg_wr,
  input  wire cfg_t       cfg_in,
  input  wire logic       rx_overflow_event,
  input  wire logic [7:0] rssi,
  input  wire logic       rssi_valid,
  output logic            chip_ready_n,
  output logic            so_out,
  output logic            so_oe,
  output logic            osc_enable,
  output logic            regulator_enable,
  output logic [4:0]      radio_state_code,
  output logic            general_output_zero,
  output logic            carrier_sense
);

  localparam int CW = $clog2(OSC_START_CYC + 1);        // Settle counter width
  localparam logic [CW-1:0] OSC_LOAD = OSC_START_CYC[CW-1:0];
  localparam logic [6:0] RST_LOAD = RESTART_CYCLES[6:0];
  localparam logic [6:0] GDO_LAST = 7'(GDO_HALF - 1);

  if (OSC_START_CYC < 1 || OSC_START_CYC > 16777215) begin : g_bad_osc
    $error("OSC_START_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State code lookup
  function automatic logic [4:0] state_code(input radio_state_t s);
    case (s)
      ST_SLEEP:       state_code = CODE_SLEEP;
      ST_IDLE:        state_code = CODE_IDLE;
      ST_OSC_OFF:     state_code = CODE_OSC_OFF;
      ST_RX:          state_code = CODE_RX;
      ST_RX_OVERFLOW: state_code = CODE_RX_OVERFLOW;
      default:        state_code = CODE_IDLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Select pin synchroniser and edges
  logic sel_meta_r;                      // First stage
  logic sel_sync_r;                      // Second stage
  logic sel_prev_r;                      // Edge history
  logic sel_fall;
  logic sel_rise;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sel_meta_r <= 1'b1;
      sel_sync_r <= 1'b1;
      sel_prev_r <= 1'b1;
    end else begin
      sel_meta_r <= select_n;
      sel_sync_r <= sel_meta_r;
      sel_prev_r <= sel_sync_r;
    end
  end

  assign sel_fall = sel_prev_r & ~sel_sync_r;
  assign sel_rise = ~sel_prev_r & sel_sync_r;

  ////////////////////////////////////////////////////////////////////////////
  // Radio control state, oscillator and regulator
  radio_state_t    state_r, state_nxt;
  logic            osc_en_r, osc_en_nxt;       // Crystal running
  logic            reg_r, reg_nxt;             // Core regulator on
  logic [CW-1:0]   osc_cnt_r, osc_cnt_nxt;     // Cycles to stability
  logic [6:0]      rst_cnt_r, rst_cnt_nxt;     // Busy after reset strobe
  cfg_t            cfg_r, cfg_nxt;             // Configuration fields
  logic            osc_stable;

  assign osc_stable = osc_en_r && (osc_cnt_r == '0);

  always_comb begin
    state_nxt   = state_r;
    osc_en_nxt  = osc_en_r;
    reg_nxt     = reg_r;
    osc_cnt_nxt = osc_cnt_r;
    rst_cnt_nxt = rst_cnt_r;
    cfg_nxt     = cfg_r;
    // Settling counts only while the crystal runs
    if (osc_en_r && osc_cnt_r != '0) osc_cnt_nxt = osc_cnt_r - 1'b1;   // [R10]
    if (rst_cnt_r != 7'h00) rst_cnt_nxt = rst_cnt_r - 7'h01;
    if (cfg_wr) cfg_nxt = cfg_in;
    case (state_r)
      ST_IDLE: begin
        if (strobes.rx_strobe && osc_stable) begin
          state_nxt = ST_RX;                                          // [R6]
        end else if (strobes.osc_off_strobe) begin
          state_nxt = ST_OSC_OFF;                                     // [R16]
        end else if (strobes.power_down_strobe) begin
          state_nxt = ST_SLEEP;                                       // [R16]
        end
      end
      ST_RX: begin
        if (strobes.idle_strobe) state_nxt = ST_IDLE;                 // [R6]
        else if (rx_overflow_event) state_nxt = ST_RX_OVERFLOW;       // [R6]
      end
      ST_RX_OVERFLOW: begin
        if (strobes.idle_strobe) state_nxt = ST_IDLE;
      end
      ST_OSC_OFF, ST_SLEEP: begin
        if (sel_fall) begin
          // Wake: regulator and crystal back on
          state_nxt  = ST_IDLE;                                       // [R20]
          reg_nxt    = 1'b1;                                          // [R20]
          osc_en_nxt = 1'b1;                                          // [R17]
        end else if (sel_rise) begin
          if (!cfg_r.osc_force_on) begin
            osc_en_nxt  = 1'b0;                                       // [R17] [R15] [R19]
            osc_cnt_nxt = OSC_LOAD;
          end
          if (state_r == ST_SLEEP) reg_nxt = 1'b0;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Reset strobe overrides state and configuration, loads busy count
    if (strobes.reset_strobe) begin
      state_nxt   = ST_IDLE;                                          // [R11]
      cfg_nxt     = CFG_RESET;                                        // [R11] [R3]
      rst_cnt_nxt = RST_LOAD;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r   <= ST_IDLE;                                           // [R9]
      osc_en_r  <= 1'b1;                                              // [R9]
      reg_r     <= 1'b1;
      osc_cnt_r <= OSC_LOAD;
      rst_cnt_r <= 7'h00;
      cfg_r     <= CFG_RESET;                                         // [R3]
    end else begin
      state_r   <= state_nxt;
      osc_en_r  <= osc_en_nxt;
      reg_r     <= reg_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      cfg_r     <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready indication, divided clock and registered outputs
  logic       ready_n_nxt;
  logic [6:0] div_r, div_nxt;            // Divider count
  logic       gclk_r, gclk_nxt;          // Divided clock
  logic       gdo_nxt;
  logic       ready_n_r, so_out_r, so_oe_r, gdo_r;
  logic [4:0] code_r;

  always_comb begin
    // Ready only once crystal settled and reset work done
    ready_n_nxt = !(osc_stable && rst_cnt_r == 7'h00 && reg_r);      // [R8] [R10]
    div_nxt     = div_r + 7'h01;
    gclk_nxt    = gclk_r;
    if (!osc_stable || strobes.reset_strobe) begin
      div_nxt  = 7'h00;
      gclk_nxt = 1'b0;
    end else if (div_r == GDO_LAST) begin
      div_nxt  = 7'h00;
      gclk_nxt = ~gclk_r;                                             // [R7]
    end
    case (cfg_r.general_output_zero_sel)
      GDO_SEL_CLK_DIV: gdo_nxt = gclk_r;                              // [R7]
      GDO_SEL_CARRIER: gdo_nxt = carrier_sense;
      default:         gdo_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_r     <= 7'h00;
      gclk_r    <= 1'b0;
      gdo_r     <= 1'b0;
      ready_n_r <= 1'b1;
      so_out_r  <= 1'b0;
      so_oe_r   <= 1'b0;
      code_r    <= CODE_IDLE;
    end else begin
      div_r     <= div_nxt;
      gclk_r    <= gclk_nxt;
      gdo_r     <= gdo_nxt;
      ready_n_r <= ready_n_nxt;
      so_out_r  <= ready_n_nxt & ~sel_sync_r;                         // [R8]
      so_oe_r   <= ~sel_sync_r;                                       // [R8]
      code_r    <= state_code(state_nxt);                             // [R18]
    end
  end

  assign chip_ready_n        = ready_n_r;
  assign so_out              = so_out_r;
  assign so_oe               = so_oe_r;
  assign osc_enable          = osc_en_r;
  assign regulator_enable    = reg_r;
  assign radio_state_code    = code_r;
  assign general_output_zero = gdo_r;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier sense
  carrier_sense_unit u_cs (
    .clock         (clock),
    .reset         (reset),
    .clear         (strobes.reset_strobe),
    .cfg           (cfg_r),
    .rssi          (rssi),
    .rssi_valid    (rssi_valid),
    .carrier_sense (carrier_sense)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rst_strobe;
    @(posedge clock) disable iff (reset)
      strobes.reset_strobe |=> state_r == ST_IDLE && cfg_r == CFG_RESET && code_r == CODE_IDLE;
  endproperty
  a_rst_strobe: assert property (p_rst_strobe) // [R11]
    else $error("Reset strobe did not restore idle");

  property p_off_from_idle;
    @(posedge clock) disable iff (reset)
      (state_r == ST_IDLE && strobes.osc_off_strobe && !strobes.reset_strobe
       && !(strobes.rx_strobe && osc_stable)) |=> state_r == ST_OSC_OFF;
  endproperty
  a_off_from_idle: assert property (p_off_from_idle) // [R16]
    else $error("Oscillator-off strobe not taken in idle");

  property p_off_not_idle;
    @(posedge clock) disable iff (reset)
      (state_r == ST_RX && strobes.power_down_strobe && !strobes.reset_strobe)
      |=> state_r != ST_SLEEP;
  endproperty
  a_off_not_idle: assert property (p_off_not_idle) // [R16]
    else $error("Power-down strobe honored outside idle");

  property p_force_on;
    @(posedge clock) disable iff (reset)
      (cfg_r.osc_force_on && osc_en_r && !cfg_wr && !strobes.reset_strobe) |=> osc_en_r;
  endproperty
  a_force_on: assert property (p_force_on) // [R19]
    else $error("Forced oscillator stopped");

  property p_stop_on_rise;
    @(posedge clock) disable iff (reset)
      ((state_r == ST_OSC_OFF || state_r == ST_SLEEP) && sel_rise && !cfg_r.osc_force_on)
      |=> !osc_en_r;
  endproperty
  a_stop_on_rise: assert property (p_stop_on_rise) // [R17]
    else $error("Crystal not stopped on select rise");

  property p_wake;
    @(posedge clock) disable iff (reset)
      (state_r == ST_SLEEP && $fell(select_n))
      |-> ##[1:3] (state_r == ST_IDLE && reg_r && osc_en_r);
  endproperty
  a_wake: assert property (p_wake) // [R20]
    else $error("Sleep not left on select low");

  property p_ready_stable;
    @(posedge clock) disable iff (reset)
      !ready_n_r |-> $past(osc_stable);
  endproperty
  a_ready_stable: assert property (p_ready_stable) // [R10]
    else $error("Ready shown before oscillator stable");

  property p_so_drive;
    @(posedge clock) disable iff (reset)
      (!sel_sync_r && !ready_n_nxt) |=> so_oe_r && !so_out_r && !chip_ready_n;
  endproperty
  a_so_drive: assert property (p_so_drive) // [R8]
    else $error("Ready not driven low on data out");

  property p_overflow;
    @(posedge clock) disable iff (reset)
      (state_r == ST_RX && rx_overflow_event && !strobes.idle_strobe && !strobes.reset_strobe)
      |=> state_r == ST_RX_OVERFLOW && code_r == CODE_RX_OVERFLOW;
  endproperty
  a_overflow: assert property (p_overflow) // [R6]
    else $error("Overflow event not followed");

  property p_code;
    @(posedge clock) disable iff (reset)
      ##1 code_r == state_code(state_r);
  endproperty
  a_code: assert property (p_code) // [R18]
    else $error("State code mismatch");

endmodule
`default_nettype wire

//--- mcu_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_pin_model import radio_ctl_pkg::*; #(
  parameter int HOLD_CYC = 10000        // Select-high hold, 40 us at 250 MHz
) (
  input  wire logic clock,
  input  wire logic so_pin,
  output logic      select_n,
  output var strobes_t strobes
);
  // Idle pins: deselected, no strobe
  initial begin
    select_n = 1'b1;
    strobes  = '0;
  end
  // Select level, changed just after an edge
  task automatic sel(input logic lvl);
    @(posedge clock) select_n <= lvl;
  endtask
  // One-cycle command strobe
  task automatic pulse(input strobes_t s);
    @(posedge clock) strobes <= s;
    @(posedge clock) strobes <= '0;
  endtask
  // Bounded wait for the serial output level
  task automatic wait_so(input logic lvl, output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 3000 && !ok; n++) begin
      @(negedge clock);
      ok = (so_pin === lvl);
    end
  endtask
  // Full start-up sequence; clock high and data low are implied by idle pins
  task automatic manual_reset(output logic ok);
    logic a;
    logic b;
    sel(1'b0);
    sel(1'b1);
    repeat (HOLD_CYC) @(posedge clock);
    sel(1'b0);
    wait_so(1'b0, a);
    pulse(5'h10);
    wait_so(1'b1, b);
    wait_so(1'b0, ok);
    ok = ok & a & b;
  endtask
endmodule
`default_nettype wire

//--- radio_reset_xosc_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module radio_reset_xosc_control_tb_top;
  import radio_ctl_pkg::*;
  localparam int SETTLE = 20;           // Shortened oscillator settle
  typedef struct packed {
    strobes_t   s;
    logic       ovf;
    logic [4:0] code;
  } step_row_t;
  // Strobe or event, then state code expected
  localparam step_row_t ROWS [12] = '{
    '{5'h01, 1'b0, CODE_RX}, '{5'h00, 1'b1, CODE_RX_OVERFLOW}, '{5'h02, 1'b0, CODE_IDLE},
    '{5'h04, 1'b0, CODE_SLEEP}, '{5'h10, 1'b0, CODE_IDLE}, '{5'h08, 1'b0, CODE_OSC_OFF},
    '{5'h04, 1'b0, CODE_OSC_OFF}, '{5'h02, 1'b0, CODE_OSC_OFF}, '{5'h10, 1'b0, CODE_IDLE},
    '{5'h01, 1'b0, CODE_RX}, '{5'h08, 1'b0, CODE_RX}, '{5'h02, 1'b0, CODE_IDLE}};
  // Offset, sample, carrier sense expected
  localparam logic [12:0] CS_ROWS [6] = '{
    {4'h7, 8'hAE, 1'b0}, {4'h7, 8'hB1, 1'b1}, {4'h7, 8'hAE, 1'b1},
    {4'h7, 8'hAB, 1'b0}, {4'h9, 8'h9C, 1'b1}, {4'h8, 8'h8F, 1'b0}};
  logic       clock = 1'b0;             // 250 MHz
  logic       reset = 1'b1;
  logic       cfg_wr = 1'b0;
  cfg_t       cfg_in = CFG_RESET;
  logic       rx_overflow_event = 1'b0;
  logic [7:0] rssi = 8'h00;
  logic       rssi_valid = 1'b0;
  logic       select_n;
  strobes_t   strobes;
  logic       chip_ready_n, so_out, so_oe, osc_enable, regulator_enable;
  logic [4:0] radio_state_code;
  logic       general_output_zero, carrier_sense;
  logic       so_last = 1'b0;           // Last driven data-out level
  logic       so_pin;
  int         errors = 0;
  int         checks = 0;
  cfg_t       c;
  logic       ok;
  int         n;
  always #2 clock = ~clock;
  // Released data-out pin shows the inverse of its last level
  always @(posedge clock) if (so_oe) so_last <= so_out;
  assign so_pin = so_oe ? so_out : ~so_last;
  radio_reset_xosc_control #(.OSC_START_CYC(SETTLE)) i_dut (
    .clock(clock), .reset(reset), .select_n(select_n), .strobes(strobes), .cfg_wr(cfg_wr),
    .cfg_in(cfg_in), .rx_overflow_event(rx_overflow_event), .rssi(rssi),
    .rssi_valid(rssi_valid), .chip_ready_n(chip_ready_n), .so_out(so_out), .so_oe(so_oe),
    .osc_enable(osc_enable), .regulator_enable(regulator_enable),
    .radio_state_code(radio_state_code), .general_output_zero(general_output_zero),
    .carrier_sense(carrier_sense));
  mcu_pin_model i_mcu (.clock(clock), .so_pin(so_pin), .select_n(select_n), .strobes(strobes));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Load configuration
  task automatic write_cfg(input cfg_t v);
    @(posedge clock) cfg_in <= v;
    cfg_wr <= 1'b1;
    @(posedge clock) cfg_wr <= 1'b0;
  endtask
  // One signal-strength sample, then settle
  task automatic feed(input logic [7:0] v);
    @(posedge clock) rssi <= v;
    rssi_valid <= 1'b1;
    @(posedge clock) rssi_valid <= 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // Verdict
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    summarize();
  end
  // Main sequence
  initial begin
    @(negedge clock);
    check({radio_state_code, chip_ready_n, osc_enable, regulator_enable}, 8'h0F);
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    i_mcu.sel(1'b0);
    repeat (4) @(negedge clock);
    check({so_oe, so_out}, 2'h3);
    i_mcu.wait_so(1'b0, ok);
    check(ok, 1'b1);
    @(posedge general_output_zero);
    n = 0;
    @(negedge clock);
    while (general_output_zero === 1'b1) begin
      n++;
      @(negedge clock);
    end
    check(n, GDO_HALF);
    foreach (ROWS[i]) begin
      if (ROWS[i].ovf) begin
        @(posedge clock) rx_overflow_event <= 1'b1;
        @(posedge clock) rx_overflow_event <= 1'b0;
      end else begin
        i_mcu.pulse(ROWS[i].s);
      end
      repeat (130) @(negedge clock);
      check(radio_state_code, ROWS[i].code);
    end
    // Crystal follows select after off and sleep strobes; last pass forces it on
    for (int k = 0; k < 3; k++) begin
      c = CFG_RESET;
      c.osc_force_on = (k == 2);
      write_cfg(c);
      i_mcu.pulse(k == 0 ? 5'h08 : 5'h04);
      i_mcu.sel(1'b1);
      repeat (6) @(negedge clock);
      check(osc_enable, k == 2);
      check(regulator_enable, k == 0);
      i_mcu.sel(1'b0);
      repeat (6) @(negedge clock);
      check({osc_enable, regulator_enable, radio_state_code}, 7'h61);
      i_mcu.wait_so(1'b0, ok);
      check(ok, 1'b1);
    end
    // Absolute threshold with hysteresis
    c = CFG_RESET;
    c.general_output_zero_sel = GDO_SEL_CARRIER;
    c.front_end_gain_ceiling = 3'h7;
    c.digital_gain_ceiling = 2'h3;
    c.channel_level_target = 3'h7;
    foreach (CS_ROWS[i]) begin
      c.cs_absolute_offset = CS_ROWS[i][12:9];
      write_cfg(c);
      feed(CS_ROWS[i][8:1]);
      check(carrier_sense, CS_ROWS[i][0]);
      check(general_output_zero, CS_ROWS[i][0]);
    end
    i_mcu.pulse(5'h10);
    repeat (130) @(negedge clock);
    check(carrier_sense, 1'b0);
    // Relative step of 6 dB
    c.cs_absolute_offset = 4'h7;
    c.cs_relative_step = 2'h1;
    write_cfg(c);
    feed(8'h80);
    feed(8'h92);
    check(carrier_sense, 1'b1);
    i_mcu.manual_reset(ok);
    check(ok, 1'b1);
    check(radio_state_code, CODE_IDLE);
    // Power-on reset again in mid-run, from receive
    i_mcu.pulse(5'h01);
    @(posedge clock) reset <= 1'b1;
    @(negedge clock);
    check({radio_state_code, chip_ready_n, osc_enable, regulator_enable}, 8'h0F);
    @(posedge clock) reset <= 1'b0;
    i_mcu.wait_so(1'b0, ok);
    check(ok, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
